/* epc_cfg.svh */
/*
  Constants of the energy-to-pulse converter: register offsets, field
  positions, reset values and timing figures.
  Assumes a 40 MHz metering clock and an 8-bit register address.
*/
`ifndef EPC_CFG_SVH
`define EPC_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define EPC_A_MEASUREMENT_MODE_ONE      8'h0B
`define EPC_A_MEASUREMENT_MODE_TWO      8'h0C
`define EPC_A_GAIN       8'h1F
`define EPC_A_ADIV       8'h26
`define EPC_A_NUM1       8'h27
`define EPC_A_DEN1       8'h28
`define EPC_A_NUM2       8'h29
`define EPC_A_DEN2       8'h2A
`define EPC_A_ENL        8'hD9
`define EPC_A_ENM        8'hDA
`define EPC_A_ENH        8'hDB
`define EPC_A_STM        8'hDD

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EPC_B_DIS1       1
`define EPC_B_DIS2       2
`define EPC_B_AHSEL      3
`define EPC_B_SEL1       4
`define EPC_B_SEL2       6
`define EPC_B_FLAG1      6

// ----------------------------------------------------------------------
// Reset values and fixed codes
// ----------------------------------------------------------------------
`define EPC_RST_BYTE     8'h00
`define EPC_RST_WORD     16'h0000
`define EPC_IRQ_VECTOR   16'h004B

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define EPC_CLK_HZ       40000000
`define EPC_HOLD_MS      90
`define EPC_LONG_MS      180
`define EPC_HOLD_CYC     ((`EPC_CLK_HZ / 1000) * `EPC_HOLD_MS)
`define EPC_LONG_CYC     ((`EPC_CLK_HZ / 1000) * `EPC_LONG_MS)

`endif

/* epc_pkg.sv */
/*
  Types of the energy-to-pulse converter.
  Assumes epc_cfg.svh is on the include path.
*/
`include "epc_cfg.svh"

package epc_pkg;

  // Source of a converter's internal pulses
  typedef enum logic [1:0] {
    EPC_SRC_ACTIVE   = 2'b00,
    EPC_SRC_REACTIVE = 2'b01,
    EPC_SRC_APPARENT = 2'b11,
    EPC_SRC_APP_ALT  = 2'b10
  } epc_src_e;

  typedef logic [22:0] epc_cnt_t;

  // Whole state of the converter
  typedef struct packed {
    logic [7:0]        measurement_mode_one;
    logic [7:0]        measurement_mode_two;
    logic [11:0]       gain;
    logic [7:0]        adiv;
    logic [1:0][15:0]  num;
    logic [1:0][15:0]  den;
    logic [7:0]        en_low;
    logic [7:0]        en_mid;
    logic [7:0]        en_high;
    logic [1:0]        flag;
    logic [7:0]        div_cnt;
    logic              ap_lsb;
    logic [1:0][16:0]  acc;
    logic [1:0][22:0]  per;
    logic [1:0][22:0]  low;
    logic [1:0]        cf;
    logic              irq;
    logic [15:0]       vec;
    logic [15:0]       rdata;
  } epc_state_s;

endpackage

/* epc_top.sv */
/*
  Energy-to-pulse converter: two converters turning energy LSB events
  into active-low calibration pulses, with mode, scaling and interrupt
  registers on the processor's special-function register port.
  Assumes energy LSB events arrive as one-cycle pulses synchronous to
  clk_in, and that other interrupt status groups are supplied as levels.
*/
// Behaviour
// - Ampere-hour bit routes rms current to apparent path
// - Ampere-hour reuses apparent gain, divider, scaling registers
// - Divider zero or one: pulse per LSB
// - Output pulse after denominator/numerator internal pulses
// - Mode one bits 1,2 disable outputs
// - Output pulses set status mid bits 6,7
// - Enabled pulse flag raises energy interrupt
// - Source select: active, reactive, apparent/rms
// - One ampere-hour bit serves both outputs
// - Long period: output low fixed 90 ms
// - Short period: 50 percent duty cycle
// - Outputs active low, idle high
// - Both scaling registers zero give full rate output
// - Sixteen-bit unsigned numerator and denominator
// - Zero scaling register acts as one
// - Ratio above one is limited to one
// - Energy interrupt uses its own vector
// - Only enabled events raise the interrupt
// - Interrupt holds until status bit written zero
`timescale 1ns/1ps
`default_nettype none
`include "epc_cfg.svh"

module epc_top #(
  parameter logic [22:0] HOLD_CYC = 23'(`EPC_HOLD_CYC),
  parameter logic [22:0] LONG_CYC = 23'(`EPC_LONG_CYC)
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic      [15:0] reg_rdata_out,
  // Energy LSB events
  input  wire logic        active_lsb_in,
  input  wire logic        reactive_lsb_in,
  input  wire logic        apparent_lsb_in,
  input  wire logic        irms_lsb_in,
  // Other interrupt status groups
  input  wire logic [7:0]  irq_status_low_in,
  input  wire logic [7:0]  irq_status_high_in,
  // Apparent path controls
  output logic             ampere_hour_select_out,
  output logic [11:0]      apparent_gain_out,
  output logic             apparent_energy_lsb_out,
  // Pulse outputs
  output logic             pulse_output_one_out,
  output logic             pulse_output_two_out,
  // Processor interrupt
  output logic             energy_irq_out,
  output logic [15:0]      irq_vector_out
);
  import epc_pkg::*;

  epc_state_s st_r;
  epc_state_s st_nxt;
  logic [1:0]       fire;
  logic [1:0]       ipulse;
  logic [1:0][15:0] eff_num;
  logic [1:0][15:0] eff_den;

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  // All registers, both converters and the status flags in one pass
  always_comb begin
    logic       src_a;
    logic [1:0] dis;
    logic [1:0] sel;
    logic [16:0] sum;
    logic [22:0] half;
    st_nxt  = st_r;
    src_a   = 1'b0;
    fire    = 2'b00;
    ipulse  = 2'b00;
    eff_num = '0;
    eff_den = '0;
    sum     = 17'h00000;
    half    = 23'h000000;
    sel     = 2'b00;
    dis     = {st_r.measurement_mode_one[`EPC_B_DIS2], st_r.measurement_mode_one[`EPC_B_DIS1]};

    // Register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        `EPC_A_MEASUREMENT_MODE_ONE: st_nxt.measurement_mode_one   = reg_wdata_in[7:0];
        `EPC_A_MEASUREMENT_MODE_TWO: st_nxt.measurement_mode_two   = reg_wdata_in[7:0];
        `EPC_A_GAIN:  st_nxt.gain    = reg_wdata_in[11:0];
        `EPC_A_ADIV:  st_nxt.adiv    = reg_wdata_in[7:0];
        `EPC_A_NUM1:  st_nxt.num[0]  = reg_wdata_in;
        `EPC_A_DEN1:  st_nxt.den[0]  = reg_wdata_in;
        `EPC_A_NUM2:  st_nxt.num[1]  = reg_wdata_in;
        `EPC_A_DEN2:  st_nxt.den[1]  = reg_wdata_in;
        `EPC_A_ENL:   st_nxt.en_low  = reg_wdata_in[7:0];
        `EPC_A_ENM:   st_nxt.en_mid  = reg_wdata_in[7:0];
        `EPC_A_ENH:   st_nxt.en_high = reg_wdata_in[7:0];
        // Writing zero clears a flag, writing one leaves it
        `EPC_A_STM: begin
          st_nxt.flag = st_r.flag & reg_wdata_in[7:6];
        end
        default: ;
      endcase
    end

    // Apparent path source; one bit serves both converters
    src_a = st_r.measurement_mode_two[`EPC_B_AHSEL] ? irms_lsb_in
                                     : apparent_lsb_in;
    // Divider shared with ampere-hour mode; 0 and 1 pass each LSB
    st_nxt.ap_lsb = 1'b0;
    if (st_r.adiv <= 8'h01) begin
      st_nxt.ap_lsb  = src_a;
      st_nxt.div_cnt = 8'h00;
    end else if (src_a) begin
      if (st_r.div_cnt + 8'h01 >= st_r.adiv) begin
        st_nxt.ap_lsb  = 1'b1;
        st_nxt.div_cnt = 8'h00;
      end else begin
        st_nxt.div_cnt = st_r.div_cnt + 8'h01;
      end
    end

    // Both converters
    for (int i = 0; i < 2; i++) begin
      sel = i == 0 ? st_r.measurement_mode_two[`EPC_B_SEL1 +: 2]
                   : st_r.measurement_mode_two[`EPC_B_SEL2 +: 2];
      // Upper select bit picks the apparent path
      case (sel)
        EPC_SRC_ACTIVE:   ipulse[i] = active_lsb_in;
        EPC_SRC_REACTIVE: ipulse[i] = reactive_lsb_in;
        default:          ipulse[i] = st_r.ap_lsb;
      endcase
      // Zero counts as one; ratio above one is clamped to one
      eff_den[i] = st_r.den[i] == 16'h0000 ? 16'h0001
                                           : st_r.den[i];
      eff_num[i] = st_r.num[i] == 16'h0000 ? 16'h0001
                                           : st_r.num[i];
      if (eff_num[i] > eff_den[i]) begin
        eff_num[i] = eff_den[i];
      end
      // Rate scaler: add numerator, emit when denominator reached
      if (ipulse[i]) begin
        sum = st_r.acc[i] + {1'b0, eff_num[i]};
        if (sum >= {1'b0, eff_den[i]}) begin
          st_nxt.acc[i] = sum - {1'b0, eff_den[i]};
          fire[i]       = ~dis[i];
        end else begin
          st_nxt.acc[i] = sum;
        end
      end
      // Period since last pulse, saturating at the long threshold
      st_nxt.per[i] = st_r.per[i] < LONG_CYC ? st_r.per[i] + 23'h000001
                                             : st_r.per[i];
      st_nxt.low[i] = st_r.low[i] != 23'h000000 ? st_r.low[i] - 23'h000001
                                                : 23'h000000;
      // Low time from the last period; a half period keeps 50% duty
      if (fire[i]) begin
        half = st_r.per[i] >> 1;
        if (half == 23'h000000) begin
          half = 23'h000001;
        end
        st_nxt.low[i] = st_r.per[i] >= LONG_CYC ? HOLD_CYC
                                                : half;
        st_nxt.per[i] = 23'h000000;
        st_nxt.flag[i] = 1'b1;            // set wins over clear
      end
      if (dis[i]) begin
        st_nxt.low[i] = 23'h000000;
      end
      // Low while the low-time counter runs, high otherwise
      st_nxt.cf[i] = st_nxt.low[i] == 23'h000000;
    end

    // Interrupt: any enabled flag of any group; energy flags held until cleared, other groups follow their input levels
    st_nxt.irq = |({st_r.flag, 6'h00} & st_r.en_mid) |
                 |(irq_status_low_in & st_r.en_low) |
                 |(irq_status_high_in & st_r.en_high);
    st_nxt.vec = `EPC_IRQ_VECTOR;

    // Read data, one cycle after the address
    case (reg_addr_in)
      `EPC_A_MEASUREMENT_MODE_ONE: st_nxt.rdata = {8'h00, st_r.measurement_mode_one};
      `EPC_A_MEASUREMENT_MODE_TWO: st_nxt.rdata = {8'h00, st_r.measurement_mode_two};
      `EPC_A_GAIN:  st_nxt.rdata = {4'h0, st_r.gain};
      `EPC_A_ADIV:  st_nxt.rdata = {8'h00, st_r.adiv};
      `EPC_A_NUM1:  st_nxt.rdata = st_r.num[0];
      `EPC_A_DEN1:  st_nxt.rdata = st_r.den[0];
      `EPC_A_NUM2:  st_nxt.rdata = st_r.num[1];
      `EPC_A_DEN2:  st_nxt.rdata = st_r.den[1];
      `EPC_A_ENL:   st_nxt.rdata = {8'h00, st_r.en_low};
      `EPC_A_ENM:   st_nxt.rdata = {8'h00, st_r.en_mid};
      `EPC_A_ENH:   st_nxt.rdata = {8'h00, st_r.en_high};
      `EPC_A_STM:   st_nxt.rdata = {8'h00, st_r.flag, 6'h00};
      default:      st_nxt.rdata = `EPC_RST_WORD;
    endcase
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  // Outputs idle high after reset so the LED stays dark
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r     <= '0;
      st_r.cf  <= 2'b11;
      st_r.vec <= `EPC_IRQ_VECTOR;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // Every output is a field of the state register
  assign reg_rdata_out           = st_r.rdata;
  assign ampere_hour_select_out  = st_r.measurement_mode_two[`EPC_B_AHSEL];
  assign apparent_gain_out       = st_r.gain;
  assign apparent_energy_lsb_out = st_r.ap_lsb;
  assign pulse_output_one_out    = st_r.cf[0];
  assign pulse_output_two_out    = st_r.cf[1];
  assign energy_irq_out          = st_r.irq;
  assign irq_vector_out          = st_r.vec;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // A pulse sets its flag and drives the output low next cycle
  a_flag_on_fire: assert property (fire[0] |=> st_r.flag[0]
    && !pulse_output_one_out)
    else $error("pulse did not set flag or drive low");

  a_long_hold: assert property (
    fire[1] && st_r.per[1] >= LONG_CYC |=> st_r.low[1] == HOLD_CYC)
    else $error("long period low time wrong");

  a_half_duty: assert property (
    fire[0] && st_r.per[0] < LONG_CYC && st_r.per[0] > 23'h000001
    |=> st_r.low[0] == $past(st_r.per[0]) >> 1)
    else $error("short period low time not half");

  a_disable_high: assert property (
    st_r.measurement_mode_one[`EPC_B_DIS1] |=> pulse_output_one_out)
    else $error("disabled output went low");

  a_ratio_one: assert property (
    ipulse[0] && !st_r.measurement_mode_one[`EPC_B_DIS1]
    && st_r.num[0] >= st_r.den[0] |-> fire[0])
    else $error("ratio one missed a pulse");

  a_ah_route: assert property (
    st_r.measurement_mode_two[`EPC_B_AHSEL] && st_r.adiv <= 8'h01 && irms_lsb_in
    |=> apparent_energy_lsb_out)
    else $error("rms current not routed");

  a_irq_enabled: assert property (
    st_r.flag[1] && st_r.en_mid[7] |=> energy_irq_out)
    else $error("enabled flag gave no interrupt");

  a_irq_masked: assert property (
    st_r.en_low == 8'h00 && st_r.en_mid == 8'h00 && st_r.en_high == 8'h00
    |=> !energy_irq_out)
    else $error("interrupt without enable");

  a_flag_clear: assert property (
    reg_wr_in && reg_addr_in == `EPC_A_STM && !reg_wdata_in[6] && !fire[0]
    |=> !st_r.flag[0])
    else $error("written zero did not clear flag");

  a_idle_high: assert property (
    st_r.low[1] == 23'h000000 && !fire[1] |=> pulse_output_two_out)
    else $error("idle output not high");

  // Second output sets its own flag and goes low
  a_flag_two: assert property (fire[1] |=> st_r.flag[1]
    && !pulse_output_two_out)
    else $error("pulse two did not set flag or drive low");

  // Disable bit two keeps the second output dark
  a_disable_two: assert property (
    st_r.measurement_mode_one[`EPC_B_DIS2] |=> pulse_output_two_out)
    else $error("disabled output two went low");

  // The vector never moves, the core jumps there blindly
  a_vector_fixed: assert property (
    irq_vector_out == `EPC_IRQ_VECTOR)
    else $error("interrupt vector changed");

  // Code zero feeds converter one from the active LSB
  a_sel_active: assert property (
    st_r.measurement_mode_two[`EPC_B_SEL1 +: 2] == 2'b00 && active_lsb_in |-> ipulse[0])
    else $error("active source not selected");

  // Code one feeds converter two from the reactive LSB
  a_sel_reactive: assert property (
    st_r.measurement_mode_two[`EPC_B_SEL2 +: 2] == 2'b01 && reactive_lsb_in |-> ipulse[1])
    else $error("reactive source not selected");

  // With the ampere-hour bit clear the apparent LSB goes through
  a_ah_apparent: assert property (
    !st_r.measurement_mode_two[`EPC_B_AHSEL] && st_r.adiv <= 8'h01 && apparent_lsb_in
    |=> apparent_energy_lsb_out)
    else $error("apparent LSB not routed");

  // An enabled flag of output one keeps the request up
  a_irq_held: assert property (
    st_r.flag[0] && st_r.en_mid[6] |=> energy_irq_out)
    else $error("interrupt dropped while flag set");

  // Long gaps give the fixed low time on output one as well
  a_long_one: assert property (
    fire[0] && st_r.per[0] >= LONG_CYC |=> st_r.low[0] == HOLD_CYC)
    else $error("long period low time wrong on one");

  // Both scaling registers at zero pass every internal pulse
  a_zero_ratio: assert property (
    ipulse[1] && !st_r.measurement_mode_one[`EPC_B_DIS2] && st_r.num[1] == 16'h0000
    && st_r.den[1] == 16'h0000 |-> fire[1])
    else $error("zero scaling missed a pulse");

  // A written zero on output two's flag clears it
  a_flag_clear_two: assert property (
    reg_wr_in && reg_addr_in == `EPC_A_STM && !reg_wdata_in[7] && !fire[1]
    |=> !st_r.flag[1])
    else $error("written zero did not clear flag two");

  c_long_hold: cover property (fire[1] && st_r.per[1] >= LONG_CYC);
  c_flag_clear: cover property (st_r.flag[0] ##1 !st_r.flag[0]);
  c_pulse_one: cover property (fire[0] ##1 !pulse_output_one_out);
  c_irq_raise: cover property (!energy_irq_out ##1 energy_irq_out);
  c_ah_pulse: cover property (st_r.measurement_mode_two[`EPC_B_AHSEL] && fire[1]);

endmodule
`default_nettype wire

/* epc_cal_meter.sv */
/*
  Calibration bench model: the optical receiver that watches both pulse
  outputs, counts pulses and measures low time and pulse period.
  Assumes the outputs are sampled on the converter clock.
*/
`timescale 1ns/1ps
`default_nettype none

module epc_cal_meter (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Light inputs, one per pulse output
  input  wire logic [1:0] led_n_in,
  // Measured figures
  output var  int         pulses_out [2],
  output var  int         low_out [2],
  output var  int         period_out [2]
);
  logic [1:0] prev_r;
  int         run_r [2];
  int         gap_r [2];

  // A pulse starts on a falling edge; the LED lights while low
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_in) begin
        prev_r[i]     <= 1'b1;
        run_r[i]      <= 0;
        gap_r[i]      <= 0;
        pulses_out[i] <= 0;
        low_out[i]    <= 0;
        period_out[i] <= 0;
      end else begin
        prev_r[i] <= led_n_in[i];
        gap_r[i]  <= gap_r[i] + 1;
        if (!led_n_in[i])
          run_r[i] <= run_r[i] + 1;
        if (prev_r[i] && !led_n_in[i]) begin
          pulses_out[i] <= pulses_out[i] + 1;
          period_out[i] <= gap_r[i];
          gap_r[i]      <= 1;
          run_r[i]      <= 1;
        end
        // Width is latched once the light goes off again
        if (!prev_r[i] && led_n_in[i])
          low_out[i] <= run_r[i];
      end
    end
  end
endmodule

`default_nettype wire

/* test_energy_to_pulse_converter.sv */
/*
  Self-checking bench of the energy-to-pulse converter.
  Assumes short hold and long-period figures (20 and 40 cycles).
*/
`timescale 1ns/1ps
`default_nettype none
`include "epc_cfg.svh"

module test_energy_to_pulse_converter;
  typedef struct packed {
    logic [7:0]  a;
    logic [15:0] d;
    logic [15:0] e;
  } epc_row_s;
  // Write value and read-back per offset; last one is unmapped
  localparam epc_row_s ROWS [13] = '{
    '{8'h0B, 16'h0006, 16'h0006}, '{8'h0C, 16'h0008, 16'h0008},
    '{8'h1F, 16'h0ABC, 16'h0ABC}, '{8'h26, 16'h0001, 16'h0001},
    '{8'h27, 16'hFFFF, 16'hFFFF}, '{8'h28, 16'h8001, 16'h8001},
    '{8'h29, 16'h1234, 16'h1234}, '{8'h2A, 16'hFEDC, 16'hFEDC},
    '{8'hD9, 16'h005A, 16'h005A}, '{8'hDA, 16'h00A5, 16'h00A5},
    '{8'hDB, 16'h003C, 16'h003C}, '{8'hDD, 16'h00FF, 16'h0000},
    '{8'h30, 16'h1111, 16'h0000}};
  // Numerator, denominator, LSBs sent, pulses expected
  localparam logic [15:0] RAT [3][4] = '{
    '{16'h0001, 16'h0003, 16'h0006, 16'h0002},
    '{16'h0000, 16'h0002, 16'h0004, 16'h0002},
    '{16'h0005, 16'h0002, 16'h0002, 16'h0002}};

  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        wr_en  = 1'b0;
  logic [7:0]  addr   = 8'h00;
  logic [7:0]  low_st = 8'h00;
  logic [7:0]  hi_st  = 8'h00;
  logic [15:0] wdata  = 16'h0000;
  logic [3:0]  lsb    = 4'h0;
  logic [15:0] rdata;
  logic [15:0] vec;
  logic [11:0] gain;
  logic        ah;
  logic        irq;
  logic [1:0]  cf;
  logic        ap;
  int          ap_n = 0;
  int          n2;
  int          pulses [2];
  int          low_w [2];
  int          per [2];
  int          n0;
  int          n1;
  int          want;
  int          bad_count   = 0;
  int          check_count = 0;

  always #12.5 clk_in = ~clk_in;

  // Counts divided apparent LSBs handed to the accumulators
  always @(posedge clk_in) begin
    if (ap === 1'b1)
      ap_n <= ap_n + 1;
  end

  epc_top #(.HOLD_CYC(23'd20), .LONG_CYC(23'd40)) epc_top_inst (
    .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wr_in(wr_en), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .active_lsb_in(lsb[0]), .reactive_lsb_in(lsb[1]),
    .apparent_lsb_in(lsb[2]), .irms_lsb_in(lsb[3]),
    .irq_status_low_in(low_st), .irq_status_high_in(hi_st),
    .ampere_hour_select_out(ah), .apparent_gain_out(gain),
    .apparent_energy_lsb_out(ap), .pulse_output_one_out(cf[0]),
    .pulse_output_two_out(cf[1]), .energy_irq_out(irq),
    .irq_vector_out(vec));

  epc_cal_meter epc_cal_meter_inst (
    .clk_in(clk_in), .rst_in(rst_in), .led_n_in(cf),
    .pulses_out(pulses), .low_out(low_w), .period_out(per));

  task automatic chk(input logic [15:0] got, input logic [15:0] e);
    check_count++;
    if (got !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr  <= a;
    wr_en <= 1'b1;
    wdata <= d;
    @(posedge clk_in);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_in);
    addr <= a;
    repeat (2) @(posedge clk_in);
    #1 chk(rdata, e);
  endtask

  // One energy LSB on input k, then idle so pulses never overlap
  task automatic hit(input int k, input int gap);
    @(posedge clk_in);
    lsb[k] <= 1'b1;
    @(posedge clk_in);
    lsb <= 4'h0;
    repeat (gap - 1) @(posedge clk_in);
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_in);
    bad_count++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    #1 chk(16'(cf), 16'h0003);
    chk(16'(irq), 16'h0000);
    chk(vec, 16'h004B);
    foreach (ROWS[i]) rd(ROWS[i].a, 16'h0000);
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a, ROWS[i].e);
    end
    chk(16'(gain), 16'h0ABC);
    chk(16'(ah), 16'h0001);
    // Both outputs follow active power, full ratio, flags enabled
    wr(`EPC_A_MEASUREMENT_MODE_ONE, 16'h0000);
    wr(`EPC_A_MEASUREMENT_MODE_TWO, 16'h0000);
    wr(`EPC_A_NUM1, 16'h0000);
    wr(`EPC_A_DEN1, 16'h0000);
    wr(`EPC_A_NUM2, 16'h0000);
    wr(`EPC_A_DEN2, 16'h0000);
    wr(`EPC_A_ENL, 16'h0000);
    wr(`EPC_A_ENH, 16'h0000);
    wr(`EPC_A_ENM, 16'h00C0);
    hit(0, 3);
    #1 chk(16'(cf), 16'h0000);
    chk(16'(irq), 16'h0001);
    repeat (76) @(posedge clk_in);
    #1 chk(16'(low_w[0]), 16'd20);
    hit(0, 30);
    hit(0, 79);
    chk(16'(per[0]), 16'd31);
    chk(16'(low_w[0]), 16'(per[0] / 2));
    rd(`EPC_A_STM, 16'h00C0);
    wr(`EPC_A_STM, 16'h00FF);
    rd(`EPC_A_STM, 16'h00C0);
    chk(16'(irq), 16'h0001);
    wr(`EPC_A_STM, 16'h0080);
    rd(`EPC_A_STM, 16'h0080);
    wr(`EPC_A_STM, 16'h0000);
    repeat (2) @(posedge clk_in);
    #1 chk(16'(irq), 16'h0000);
    // Masked flags and the other status groups
    wr(`EPC_A_ENM, 16'h0000);
    hit(0, 40);
    rd(`EPC_A_STM, 16'h00C0);
    chk(16'(irq), 16'h0000);
    wr(`EPC_A_STM, 16'h0000);
    low_st <= 8'hFB;
    wr(`EPC_A_ENL, 16'h0004);
    repeat (3) @(posedge clk_in);
    #1 chk(16'(irq), 16'h0000);
    low_st <= 8'h04;
    repeat (3) @(posedge clk_in);
    #1 chk(16'(irq), 16'h0001);
    low_st <= 8'h00;
    hi_st  <= 8'h01;
    wr(`EPC_A_ENH, 16'h0001);
    repeat (2) @(posedge clk_in);
    #1 chk(16'(irq), 16'h0001);
    hi_st <= 8'h00;
    repeat (3) @(posedge clk_in);
    #1 chk(16'(irq), 16'h0000);
    // Output disables, one at a time
    for (int d = 0; d < 2; d++) begin
      wr(`EPC_A_MEASUREMENT_MODE_ONE, 16'(2 << d));
      n0 = pulses[0];
      n1 = pulses[1];
      hit(0, 40);
      chk(16'(pulses[0] - n0), 16'(d));
      chk(16'(pulses[1] - n1), 16'(1 - d));
      rd(`EPC_A_STM, d ? 16'h0040 : 16'h0080);
      wr(`EPC_A_STM, 16'h0000);
    end
    wr(`EPC_A_MEASUREMENT_MODE_ONE, 16'h0000);
    // Scaling ratios on output one; software keeps below one but one case
    // crosses it on purpose
    for (int i = 0; i < 3; i++) begin
      wr(`EPC_A_NUM1, RAT[i][0]);
      wr(`EPC_A_DEN1, RAT[i][1]);
      n0 = pulses[0];
      repeat (int'(RAT[i][2])) hit(0, 49);
      chk(16'(pulses[0] - n0), RAT[i][3]);
    end
    wr(`EPC_A_NUM1, 16'h0000);
    wr(`EPC_A_DEN1, 16'h0000);
    // Every source select code, both ampere-hour settings, divider one
    for (int s = 0; s < 8; s++) begin
      wr(`EPC_A_MEASUREMENT_MODE_TWO, {8'h00, s[2:1], s[2:1], s[0], 3'b000});
      #1 chk(16'(ah), 16'(s[0]));
      for (int k = 0; k < 4; k++) begin
        n0 = pulses[0];
        n1 = pulses[1];
        n2 = ap_n;
        hit(k, 49);
        want = (s[2:1] == 2'b00) ? 0 : (s[2:1] == 2'b01) ? 1 : 2 + s[0];
        chk(16'(pulses[1] - n1), 16'(k == want));
        chk(16'(pulses[0] - n0), 16'(k == want));
        chk(16'(ap_n - n2), 16'(k == 2 + s[0]));
      end
    end
    // Reset in mid-run: outputs idle, registers back to zero
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    #1 chk(16'(cf), 16'h0003);
    chk(16'(irq), 16'h0000);
    chk(16'(ah), 16'h0000);
    rd(`EPC_A_MEASUREMENT_MODE_TWO, 16'h0000);
    give_verdict();
  end
endmodule

`default_nettype wire
